/* core/sosr_regs.sv */
// Holds the override, sync monitor, converter trigger and readback registers.
// Assumes a decoded byte port from the serial register interface, synchronous to clock.
`timescale 1ns/1ps
`include "sosr_defs.svh"

module sosr_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [8:0] auto_band,
    input wire logic auto_core,
    input wire logic [5:0] auto_bias_core0,
    input wire logic [5:0] auto_bias_core1,
    input wire logic [8:0] manual_band_value,
    input wire logic manual_core_value,
    input wire logic [5:0] manual_bias_value,
    output logic [8:0] selected_band,
    output logic selected_core,
    output logic [5:0] core0_bias_value,
    output logic [5:0] core1_bias_value,
    input wire logic sync_check_valid,
    input wire logic sync_check_pass,
    output logic sync_monitor_powerdown,
    output logic sync_receiver_lvds,
    output logic adc_convert_trigger,
    input wire logic adc_busy,
    input wire logic [8:0] chip_temp,
    input wire logic [23:0] freq_count_value,
    input wire logic table_build_busy,
    input wire logic delay_strobe_flag,
    input wire logic delay_direction_flag,
    input wire logic reference_ok,
    input wire logic calibration_active,
    input wire logic pll_locked,
    output logic [7:0] spare_control
);

    // ****************************************
    // Declarations
    // ****************************************
    sosr_pkg::sosr_byte_type override_reg;
    sosr_pkg::sosr_byte_type sync_reg;
    sosr_pkg::sosr_byte_type trigger_reg;
    sosr_pkg::sosr_byte_type status_byte;
    sosr_pkg::sosr_byte_type next_rdata;
    sosr_pkg::sosr_adc_state_type adc_state;
    sosr_pkg::sosr_adc_state_type next_adc_state;
    logic sync_ok;
    logic start_write;
    logic band_override_enable;
    logic core_override_enable;
    logic bias_override_enable;
    logic sync_monitor_latch_clear;

    // Write decode of the conversion trigger
    assign start_write = reg_write && (reg_addr == `SOSR_OFS_ADC_TRIG)
        && reg_wdata[`SOSR_ADC_START_BIT];

    // ****************************************
    // Writable registers
    // ****************************************
    // Override selects, reserved bits kept as stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            override_reg <= `SOSR_RESET_BYTE;
        end else if (reg_write && (reg_addr == `SOSR_OFS_OVERRIDE)) begin
            override_reg <= reg_wdata;
        end
    end

    // Spare control byte drives its own output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            spare_control <= `SOSR_RESET_BYTE;
        end else if (reg_write && (reg_addr == `SOSR_OFS_UNNAMED)) begin
            spare_control <= reg_wdata;
        end
    end

    // Sync monitor control
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_reg <= `SOSR_RESET_BYTE;
        end else if (reg_write && (reg_addr == `SOSR_OFS_SYNC_CTRL)) begin
            sync_reg <= reg_wdata;
        end
    end

    // Trigger register keeps only its start bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trigger_reg <= `SOSR_RESET_BYTE;
        end else if (reg_write && (reg_addr == `SOSR_OFS_ADC_TRIG)) begin
            trigger_reg <= {7'h00, reg_wdata[`SOSR_ADC_START_BIT]};
        end
    end

    // Control bits taken straight from their flops
    assign band_override_enable = override_reg[`SOSR_OVR_BAND_BIT];
    assign core_override_enable = override_reg[`SOSR_OVR_CORE_BIT];
    assign bias_override_enable = override_reg[`SOSR_OVR_BIAS_BIT];
    assign sync_monitor_powerdown = sync_reg[`SOSR_SYNC_PD_BIT];
    assign sync_receiver_lvds = sync_reg[`SOSR_SYNC_LVDS_BIT];
    assign sync_monitor_latch_clear = sync_reg[`SOSR_SYNC_CLR_BIT];

    // ****************************************
    // Source selection
    // ****************************************
    // Band code from calibration or manual value
    sosr_source_select #(.WIDTH(`SOSR_BAND_W)) band_select (
        .clock(clock),
        .rst(rst),
        .override_enable(band_override_enable),
        .auto_value(auto_band),
        .manual_value(manual_band_value),
        .selected(selected_band)
    );

    // Core choice from calibration or manual value
    sosr_source_select #(.WIDTH(1)) core_select (
        .clock(clock),
        .rst(rst),
        .override_enable(core_override_enable),
        .auto_value(auto_core),
        .manual_value(manual_core_value),
        .selected(selected_core)
    );

    // Bias code of core 0
    sosr_source_select #(.WIDTH(`SOSR_BIAS_W)) bias0_select (
        .clock(clock),
        .rst(rst),
        .override_enable(bias_override_enable),
        .auto_value(auto_bias_core0),
        .manual_value(manual_bias_value),
        .selected(core0_bias_value)
    );

    // Bias code of core 1
    sosr_source_select #(.WIDTH(`SOSR_BIAS_W)) bias1_select (
        .clock(clock),
        .rst(rst),
        .override_enable(bias_override_enable),
        .auto_value(auto_bias_core1),
        .manual_value(manual_bias_value),
        .selected(core1_bias_value)
    );

    // ****************************************
    // Sync monitor latch
    // ****************************************
    sosr_sync_monitor_latch sync_latch (
        .clock(clock),
        .rst(rst),
        .powerdown(sync_monitor_powerdown),
        .latch_clear(sync_monitor_latch_clear),
        .check_valid(sync_check_valid),
        .check_pass(sync_check_pass),
        .sync_ok(sync_ok)
    );

    // ****************************************
    // Converter request
    // ****************************************
    // Launch one pulse, then wait for the converter to go idle
    always_comb begin
        next_adc_state = adc_state;
        case (adc_state)
            sosr_pkg::SOSR_ADC_IDLE: begin
                if (start_write) begin
                    next_adc_state = sosr_pkg::SOSR_ADC_LAUNCH;
                end
            end
            sosr_pkg::SOSR_ADC_LAUNCH: begin
                next_adc_state = sosr_pkg::SOSR_ADC_CONVERT;
            end
            sosr_pkg::SOSR_ADC_CONVERT: begin
                if (!adc_busy) begin
                    next_adc_state = sosr_pkg::SOSR_ADC_IDLE;
                end
            end
            default: begin
                next_adc_state = sosr_pkg::SOSR_ADC_IDLE;
            end
        endcase
    end

    // Request state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adc_state <= sosr_pkg::SOSR_ADC_IDLE;
        end else begin
            adc_state <= next_adc_state;
        end
    end

    // Start pulse, one cycle wide
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adc_convert_trigger <= 1'b0;
        end else begin
            adc_convert_trigger <= (adc_state == sosr_pkg::SOSR_ADC_IDLE) && start_write;
        end
    end

    // ****************************************
    // Status and read path
    // ****************************************
    // Live status; only the sync flag is latched
    assign status_byte = {
        table_build_busy,
        sync_ok,
        delay_strobe_flag,
        delay_direction_flag,
        reference_ok,
        adc_busy || (adc_state != sosr_pkg::SOSR_ADC_IDLE),
        calibration_active,
        pll_locked
    };

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            `SOSR_OFS_OVERRIDE: next_rdata = override_reg;
            `SOSR_OFS_UNNAMED: next_rdata = spare_control;
            `SOSR_OFS_SYNC_CTRL: next_rdata = sync_reg;
            `SOSR_OFS_ADC_TRIG: next_rdata = trigger_reg;
            `SOSR_OFS_COUNT_LOW: next_rdata = freq_count_value[7:0];
            `SOSR_OFS_COUNT_MID: next_rdata = freq_count_value[15:8];
            `SOSR_OFS_COUNT_HIGH: next_rdata = freq_count_value[23:16];
            `SOSR_OFS_STATUS: next_rdata = status_byte;
            `SOSR_OFS_BIAS0: next_rdata = {2'b00, core0_bias_value};
            `SOSR_OFS_BIAS1: next_rdata = {2'b00, core1_bias_value};
            `SOSR_OFS_TEMP_MAG: next_rdata = chip_temp[7:0];
            `SOSR_OFS_TEMP_SIGN: next_rdata = {7'h00, chip_temp[8]};
            `SOSR_OFS_BAND_LOW: next_rdata = selected_band[7:0];
            `SOSR_OFS_BAND_HIGH: next_rdata = {6'h00, selected_core, selected_band[8]};
            default: next_rdata = `SOSR_RESET_BYTE;
        endcase
    end

    // Read data register; reading changes no state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= `SOSR_RESET_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking chk_clk @(posedge clock); endclocking
    default disable iff (rst);

    sequence seq_start_taken;
        start_write && (adc_state == sosr_pkg::SOSR_ADC_IDLE);
    endsequence

    sequence seq_single_pulse;
        adc_convert_trigger ##1 !adc_convert_trigger;
    endsequence

    chk_band_manual_path: assert property (
        band_override_enable |=> selected_band == $past(manual_band_value)
    ) else $error("Band not taken from manual value");

    chk_core_auto_path: assert property (
        !core_override_enable |=> selected_core == $past(auto_core)
    ) else $error("Core not taken from calibration");

    chk_bias_override: assert property (
        bias_override_enable |=> (core0_bias_value == $past(manual_bias_value))
            && (core1_bias_value == $past(manual_bias_value))
    ) else $error("Bias override not applied");

    chk_sync_control_write: assert property (
        reg_write && (reg_addr == `SOSR_OFS_SYNC_CTRL)
        |=> (sync_monitor_powerdown == $past(reg_wdata[`SOSR_SYNC_PD_BIT]))
            && (sync_receiver_lvds == $past(reg_wdata[`SOSR_SYNC_LVDS_BIT]))
    ) else $error("Sync control bits not written");

    chk_adc_single_start: assert property (
        seq_start_taken |=> seq_single_pulse
    ) else $error("Conversion start not a single pulse");

    chk_adc_busy_flag: assert property (
        reg_read && (reg_addr == `SOSR_OFS_STATUS) && (adc_convert_trigger || adc_busy)
        |=> reg_rdata[2]
    ) else $error("Busy flag low during launch");

    chk_status_live: assert property (
        reg_read && (reg_addr == `SOSR_OFS_STATUS)
        |=> reg_rvalid && (reg_rdata[1] == $past(calibration_active))
            && (reg_rdata[0] == $past(pll_locked))
            && (reg_rdata[3] == $past(reference_ok))
    ) else $error("Status flags not live");

    chk_count_high_byte: assert property (
        reg_read && (reg_addr == `SOSR_OFS_COUNT_HIGH)
        |=> reg_rdata == $past(freq_count_value[23:16])
    ) else $error("Counter high byte wrong");

    chk_temp_sign_byte: assert property (
        reg_read && (reg_addr == `SOSR_OFS_TEMP_SIGN)
        |=> reg_rdata == {7'h00, $past(chip_temp[8])}
    ) else $error("Temperature sign byte wrong");

    chk_band_high_byte: assert property (
        reg_read && (reg_addr == `SOSR_OFS_BAND_HIGH)
        |=> reg_rdata == {6'h00, $past(selected_core), $past(selected_band[8])}
    ) else $error("Band high byte wrong");

    chk_read_no_effect: assert property (
        reg_read && !reg_write |=> $stable(override_reg) && $stable(sync_reg)
    ) else $error("Read changed a control register");

endmodule

/* core/sosr_source_select.sv */
// Holds a registered choice between an automatic and a manual code.
// Assumes all inputs are synchronous to clock.
`timescale 1ns/1ps

module sosr_source_select #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic override_enable,
    input wire logic [WIDTH-1:0] auto_value,
    input wire logic [WIDTH-1:0] manual_value,
    output logic [WIDTH-1:0] selected
);

    // ****************************************
    // Selection register
    // ****************************************
    // Manual code wins while the override is set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            selected <= '0;
        end else begin
            selected <= override_enable ? manual_value : auto_value;
        end
    end

endmodule

/* core/sosr_sync_monitor_latch.sv */
// Holds the output latch of the sync setup/hold monitor.
// Assumes check_valid pulses once per sync check, with check_pass valid beside it.
`timescale 1ns/1ps

module sosr_sync_monitor_latch (
    input wire logic clock,
    input wire logic rst,
    input wire logic powerdown,
    input wire logic latch_clear,
    input wire logic check_valid,
    input wire logic check_pass,
    output logic sync_ok
);

    // ****************************************
    // Output latch
    // ****************************************
    // Clear and power-down dominate a check result
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_ok <= 1'b0;
        end else if (powerdown || latch_clear) begin
            sync_ok <= 1'b0;
        end else if (check_valid) begin
            sync_ok <= check_pass;
        end
    end

    chk_latch_held_clear: assert property (
        @(posedge clock) disable iff (rst)
        latch_clear[*2] |-> !sync_ok
    ) else $error("Sync latch not held clear");

endmodule

/* include/sosr_defs.svh */
// Holds register offsets, field positions and reset values of the synth override/status slice.
// Assumes byte-wide registers decoded from a 12-bit register address.
`ifndef SOSR_DEFS_SVH
`define SOSR_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SOSR_ADDR_W 12
`define SOSR_OFS_OVERRIDE 12'h04D
`define SOSR_OFS_UNNAMED 12'h04F
`define SOSR_OFS_SYNC_CTRL 12'h053
`define SOSR_OFS_ADC_TRIG 12'h054
`define SOSR_OFS_COUNT_LOW 12'h055
`define SOSR_OFS_COUNT_MID 12'h056
`define SOSR_OFS_COUNT_HIGH 12'h057
`define SOSR_OFS_STATUS 12'h058
`define SOSR_OFS_BIAS0 12'h059
`define SOSR_OFS_BIAS1 12'h05A
`define SOSR_OFS_TEMP_MAG 12'h05B
`define SOSR_OFS_TEMP_SIGN 12'h05C
`define SOSR_OFS_BAND_LOW 12'h05E
`define SOSR_OFS_BAND_HIGH 12'h05F

// ****************************************
// Field positions and reset values
// ****************************************
`define SOSR_OVR_CORE_BIT 0
`define SOSR_OVR_BAND_BIT 1
`define SOSR_OVR_BIAS_BIT 2
`define SOSR_SYNC_PD_BIT 6
`define SOSR_SYNC_LVDS_BIT 5
`define SOSR_SYNC_CLR_BIT 1
`define SOSR_ADC_START_BIT 0
`define SOSR_RESET_BYTE 8'h00
`define SOSR_BAND_W 9
`define SOSR_BIAS_W 6
`define SOSR_COUNT_W 24
`define SOSR_TEMP_W 9

`endif

/* include/sosr_pkg.sv */
// Holds the shared types of the synth override/status slice.
// Assumes the constants header is compiled alongside.
package sosr_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [7:0] sosr_byte_type;

    // Tracks one auxiliary converter request
    typedef enum logic [1:0] {
        SOSR_ADC_IDLE = 2'b00,
        SOSR_ADC_LAUNCH = 2'b01,
        SOSR_ADC_CONVERT = 2'b10
    } sosr_adc_state_type;

endpackage

/* tb/sosr_host_model.sv */
// Holds a behavioural host that reaches the register slice through its byte port.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps

module sosr_host_model (
    input wire logic clock,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    // Idle port at time zero
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // One write strobe for one rising edge, then the bus shows the inverse
    task automatic write_reg(input logic [11:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask

    // One read strobe for one rising edge; data comes back a cycle later
    task automatic read_reg(input logic [11:0] addr);
        @(negedge clock);
        reg_addr = addr;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ~addr;
    endtask
endmodule

/* tb/testbench.sv */
// Holds the self-checking bench of the override and status register slice.
// Assumes the host model drives the byte port and the bench plays converter and monitor.
`timescale 1ns/1ps

module testbench;
    logic clock, rst, reg_write, reg_read, reg_rvalid;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, spare_control;
    logic [8:0] auto_band, manual_band_value, selected_band, chip_temp;
    logic auto_core, manual_core_value, selected_core;
    logic [5:0] auto_bias_core0, auto_bias_core1, manual_bias_value;
    logic [5:0] core0_bias_value, core1_bias_value;
    logic sync_check_valid, sync_check_pass, sync_monitor_powerdown, sync_receiver_lvds;
    logic adc_convert_trigger, table_build_busy, delay_strobe_flag, delay_direction_flag;
    logic reference_ok, calibration_active, pll_locked;
    logic adc_busy = 1'b0;
    logic [23:0] freq_count_value;
    logic sync_exp;
    logic [8:0] eb;
    logic ec;
    logic [7:0] d;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    int n_trig = 0;
    int busy_cnt = 0;

    sosr_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read));

    sosr_regs uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .auto_band(auto_band), .auto_core(auto_core),
        .auto_bias_core0(auto_bias_core0), .auto_bias_core1(auto_bias_core1),
        .manual_band_value(manual_band_value), .manual_core_value(manual_core_value),
        .manual_bias_value(manual_bias_value), .selected_band(selected_band),
        .selected_core(selected_core), .core0_bias_value(core0_bias_value),
        .core1_bias_value(core1_bias_value), .sync_check_valid(sync_check_valid),
        .sync_check_pass(sync_check_pass), .sync_monitor_powerdown(sync_monitor_powerdown),
        .sync_receiver_lvds(sync_receiver_lvds), .adc_convert_trigger(adc_convert_trigger),
        .adc_busy(adc_busy), .chip_temp(chip_temp), .freq_count_value(freq_count_value),
        .table_build_busy(table_build_busy), .delay_strobe_flag(delay_strobe_flag),
        .delay_direction_flag(delay_direction_flag), .reference_ok(reference_ok),
        .calibration_active(calibration_active), .pll_locked(pll_locked),
        .spare_control(spare_control));

    // ****************************************
    // Clock, converter stand-in and monitor
    // ****************************************
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Converter stays busy for a while after each start pulse
    always @(negedge clock) begin
        if (adc_convert_trigger === 1'b1) begin
            busy_cnt = 12;
        end else if (busy_cnt > 0) begin
            busy_cnt--;
        end
        adc_busy = (busy_cnt > 0);
    end

    // Counts start pulses, one per high edge
    always @(posedge clock) begin
        if (adc_convert_trigger === 1'b1) begin
            n_trig++;
        end
    end

    // Takes the oldest expected read value whenever read data is valid
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("ERROR at %0t: unexpected read data %h", $time, reg_rdata);
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.read_reg(a);
    endtask

    // One monitor check result; pass line shows the inverse once released
    task automatic sync_pulse(input logic p);
        @(negedge clock);
        sync_check_valid = 1'b1;
        sync_check_pass = p;
        @(negedge clock);
        sync_check_valid = 1'b0;
        sync_check_pass = ~p;
    endtask

    function automatic logic [7:0] status_exp(input logic busy);
        return {table_build_busy, sync_exp, delay_strobe_flag, delay_direction_flag,
            reference_ok, busy, calibration_active, pll_locked};
    endfunction

    task results;
        $display("Comparisons: %0d, mismatches: %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #200000;
        n_errors++;
        $display("ERROR at %0t: watchdog expired %h %h", $time, 1'b1, 1'b0);
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {auto_band, auto_core, auto_bias_core0, auto_bias_core1} = 22'h000000;
        {manual_band_value, manual_core_value, manual_bias_value} = 16'h0000;
        {sync_check_valid, sync_check_pass, chip_temp, freq_count_value} = 35'h000000000;
        {table_build_busy, delay_strobe_flag, delay_direction_flag} = 3'h0;
        {reference_ok, calibration_active, pll_locked} = 3'h0;
        sync_exp = 1'b0;
        void'($urandom(32'h8de6));
        rst = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        // Every register and the unmapped places between them read zero after reset
        for (int a = 12'h04D; a <= 12'h05F; a++) begin
            rd(12'(a), 8'h00);
        end
        // Manual against automatic choice, every override combination
        for (int m = 0; m < 8; m++) begin
            {auto_band, auto_core, auto_bias_core0, auto_bias_core1} = 22'($urandom());
            {manual_band_value, manual_core_value, manual_bias_value} = 16'($urandom());
            d = {5'($urandom()), 3'(m)};
            host.write_reg(12'h04D, d);
            repeat (2) @(negedge clock);
            eb = m[1] ? manual_band_value : auto_band;
            ec = m[0] ? manual_core_value : auto_core;
            check(selected_band, eb);
            check(selected_core, ec);
            check(core0_bias_value, m[2] ? manual_bias_value : auto_bias_core0);
            check(core1_bias_value, m[2] ? manual_bias_value : auto_bias_core1);
            rd(12'h04D, d);
            rd(12'h05E, eb[7:0]);
            rd(12'h05F, {6'h00, ec, eb[8]});
            rd(12'h059, {2'b00, m[2] ? manual_bias_value : auto_bias_core0});
            rd(12'h05A, {2'b00, m[2] ? manual_bias_value : auto_bias_core1});
            d = 8'($urandom());
            host.write_reg(12'h04F, d);
            @(negedge clock);
            check(spare_control, d);
        end
        // Power-down and receiver choice
        for (int k = 0; k < 4; k++) begin
            d = {1'($urandom()), 2'(k), 3'($urandom()), 1'b0, 1'($urandom())};
            host.write_reg(12'h053, d);
            @(negedge clock);
            check(sync_monitor_powerdown, d[6]);
            check(sync_receiver_lvds, d[5]);
            rd(12'h053, d);
        end
        // Monitor latch: set, clear wins, released, powered down
        host.write_reg(12'h053, 8'h00);
        sync_pulse(1'b1);
        sync_exp = 1'b1;
        rd(12'h058, status_exp(1'b0));
        sync_pulse(1'b0);
        sync_exp = 1'b0;
        rd(12'h058, status_exp(1'b0));
        sync_pulse(1'b1);
        host.write_reg(12'h053, 8'h02);
        sync_pulse(1'b1);
        rd(12'h058, status_exp(1'b0));
        host.write_reg(12'h053, 8'h00);
        rd(12'h058, status_exp(1'b0));
        sync_pulse(1'b1);
        sync_exp = 1'b1;
        rd(12'h058, status_exp(1'b0));
        host.write_reg(12'h053, 8'h40);
        sync_pulse(1'b1);
        sync_exp = 1'b0;
        rd(12'h058, status_exp(1'b0));
        host.write_reg(12'h053, 8'h00);
        // Live flags, counter and temperature; writes to read-only places ignored
        for (int n = 0; n < 6; n++) begin
            {table_build_busy, delay_strobe_flag, delay_direction_flag} = 3'($urandom());
            {reference_ok, calibration_active, pll_locked} = 3'($urandom());
            freq_count_value = 24'($urandom());
            chip_temp = 9'($urandom());
            host.write_reg(12'h055 + 12'(n), 8'($urandom()));
            rd(12'h058, status_exp(1'b0));
            rd(12'h058, status_exp(1'b0));
            rd(12'h055, freq_count_value[7:0]);
            rd(12'h056, freq_count_value[15:8]);
            rd(12'h057, freq_count_value[23:16]);
            rd(12'h05B, chip_temp[7:0]);
            rd(12'h05C, {7'h00, chip_temp[8]});
        end
        // Converter start, busy flag, start refused while busy
        host.write_reg(12'h054, 8'hFF);
        @(negedge clock);
        check(n_trig, 1);
        rd(12'h054, 8'h01);
        rd(12'h058, status_exp(1'b1));
        host.write_reg(12'h054, 8'h01);
        for (int i = 0; i < 50 && adc_busy; i++) begin
            @(negedge clock);
        end
        repeat (2) @(negedge clock);
        check(n_trig, 1);
        rd(12'h058, status_exp(1'b0));
        host.write_reg(12'h054, 8'h01);
        host.write_reg(12'h054, 8'h00);
        @(negedge clock);
        check(n_trig, 2);
        rd(12'h054, 8'h00);
        repeat (20) @(negedge clock);
        check(exp_q.size(), 0);
        results();
    end
endmodule
